// File: hdl/ifcp_pkg.sv
// Purpose: shared constants for the IF processor control port
// Assumes: byte-wide register port, 250 MHz clock
// Notes:   offsets are byte addresses 0 to 7
package ifcp_pkg;
    // =========================================================
    // register offsets
    localparam logic [2:0] ADDR_DETECTOR   = 3'h0;
    localparam logic [2:0] ADDR_RELAY      = 3'h1;
    localparam logic [2:0] ADDR_LAMP_LOW   = 3'h2;
    localparam logic [2:0] ADDR_LAMP_HIGH  = 3'h3;
    localparam logic [2:0] ADDR_SYNTH_SEL  = 3'h4;
    localparam logic [2:0] ADDR_SYNTH_DATA = 3'h5;
    localparam logic [2:0] ADDR_SW_DIR     = 3'h6;
    localparam logic [2:0] ADDR_SW_VALUE   = 3'h7;
    // =========================================================
    // field positions
    localparam int BUSY_BIT       = 7;
    localparam int LOCK_LSB       = 4;
    localparam int DET_WIDTH      = 3;
    // =========================================================
    // lamp and relay bits, both box variants
    localparam logic [7:0] LAMP_LOW_TEST   = 8'h10;
    localparam logic [7:0] LAMP_LOW_NULL   = 8'h20;
    localparam logic [7:0] LAMP_HIGH_RX_A  = 8'h01;
    localparam logic [7:0] LAMP_HIGH_RX_B  = 8'h02;
    localparam logic [7:0] LAMP_HIGH_ARRAY = 8'h04;
    localparam logic [7:0] RELAY_OUTPUTS   = 8'h0F;
    localparam logic [7:0] RELAY_TEST_NULL = 8'h10;
    localparam logic [7:0] RELAY_CAL_PATH  = 8'h20;
    localparam logic [7:0] RELAY_RX_SELECT = 8'h40;
    localparam logic [7:0] SOURCE_TEST     = 8'h10;
    localparam logic [7:0] SOURCE_NULL     = 8'h20;
    // =========================================================
    // reset values
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    // =========================================================
    // timing
    localparam int CLOCK_MHZ       = 250;
    localparam int EDGE_SPACING_US = 500;
    localparam int EDGE_CYCLES     = EDGE_SPACING_US * CLOCK_MHZ;
    localparam int BITS_PER_BYTE   = 8;
endpackage : ifcp_pkg

// File: hdl/ifcp_if.sv
// Purpose: register port between host control card and I/O card
// Assumes: one clock shared by both ends
// Notes:   read data stands the cycle after the read strobe
`timescale 1ns/10ps
interface ifcp_if (
    input wire logic clock_i
);
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport host (
        output addr,
        output wdata,
        output wr,
        output rd,
        input  rdata
    );
    modport device (
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        output rdata
    );
endinterface : ifcp_if

// File: hdl/ifcp_host.sv
// Purpose: host-side control card, forwards software access to the I/O card
// Assumes: software port of address, data, strobes; same clock as device
`timescale 1ns/10ps
module ifcp_host (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    ifcp_if.host            link,
    input  wire logic [2:0] sw_addr_i,
    input  wire logic [7:0] sw_wdata_i,
    input  wire logic       sw_wr_i,
    input  wire logic       sw_rd_i,
    output logic      [7:0] sw_rdata_o
);
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       rd_pend;
        logic [7:0] rdata;
    } ifcp_host_t;

    ifcp_host_t st;
    ifcp_host_t next_st;

    // =========================================================
    // forwarding; belong to host software
    always_comb begin
        next_st         = st;
        next_st.addr    = sw_addr_i;
        next_st.wdata   = sw_wdata_i;
        next_st.wr      = sw_wr_i;
        next_st.rd      = sw_rd_i;
        next_st.rd_pend = st.rd;
        if (st.rd_pend) begin
            next_st.rdata = link.rdata;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.addr  = st.addr;
    assign link.wdata = st.wdata;
    assign link.wr    = st.wr;
    assign link.rd    = st.rd;
    assign sw_rdata_o = st.rdata;
endmodule : ifcp_host

// File: hdl/ifcp_device.sv
// Purpose: IF processor I/O card register bank and synthesizer shifter
// Assumes: 250 MHz clock, lock, contact and switch inputs asynchronous
// Notes:   switch lines are three-signal bidirectional pins
//
// Notes on behaviour
// - address 0 write latches detector bits 0-2
// - address 1 drives relays, reads contacts
// - addresses 2 and 3 set lamps, write-only
// - address 4 bits 0-3 select synthesizers
// - address 4 bits 4-7 read lock state
// - address 5 write sends byte, busy bit 7
// - address 6 sets switch line direction
// - address 7 writes and reads switch lines
// - serial edges spaced 500 us in hardware
// - MSB first, same data to all selected
// - host polls busy between bytes, then deselects
// - lamps one to four show lock state
// - lamp bit assignments per box variant
// - relay readback is contact position
// - host cycles each relay at startup
// - fine box relay bit meanings
// - fine box sources switch as group
// - coarse box relay bit meanings
// - coarse source code bit per channel
// - test 0x10, null 0x20 source codes
// - host restores source after null mode
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module ifcp_device (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    ifcp_if.device          link,
    input  wire logic [7:0] relay_contact_i,
    input  wire logic [3:0] synth_locked_i,
    input  wire logic [7:0] switch_in_i,
    output logic      [2:0] detector_o,
    output logic      [7:0] relay_drive_o,
    output logic     [15:0] lamp_o,
    output logic      [3:0] synth_pick_o,
    output logic            synth_clock_o,
    output logic            synth_data_o,
    output logic      [7:0] switch_out_o,
    output logic      [7:0] switch_oe_o
);
    localparam int CW = $clog2(ifcp_pkg::EDGE_CYCLES + 1);

    typedef struct packed {
        // register contents
        logic [2:0]    det;
        logic [7:0]    relay;
        logic [15:0]   lamp;
        logic [3:0]    sel;
        logic [7:0]    sw_dir;
        logic [7:0]    sw_val;
        // two-flop synchronisers, pin side first
        logic [7:0]    contact_m;
        logic [7:0]    contact;
        logic [3:0]    lock_m;
        logic [3:0]    lock;
        logic [7:0]    swin_m;
        logic [7:0]    swin;
        // shift engine
        logic          busy;
        logic [7:0]    shift;
        logic [3:0]    nbits;
        logic          sclk;
        logic [CW-1:0] cnt;
        // read data, one cycle after the strobe
        logic [7:0]    rdata;
    } ifcp_dev_t;

    ifcp_dev_t st;
    ifcp_dev_t next_st;

    // =========================================================
    // register access and shift engine
    always_comb begin
        next_st           = st;

        // =========================================================
        // pin synchronisers
        next_st.contact_m = relay_contact_i;
        next_st.contact   = st.contact_m;
        next_st.lock_m    = synth_locked_i;
        next_st.lock      = st.lock_m;
        next_st.swin_m    = switch_in_i;
        next_st.swin      = st.swin_m;
        next_st.lamp[3:0] = st.lock;

        // =========================================================
        // register writes
        if (link.wr) begin
            unique case (link.addr)
                ifcp_pkg::ADDR_DETECTOR: begin
                    next_st.det = link.wdata[ifcp_pkg::DET_WIDTH-1:0];
                end
                ifcp_pkg::ADDR_RELAY: begin
                    next_st.relay = link.wdata;
                end
                // lamp latches, low four lamps belong to lock
                ifcp_pkg::ADDR_LAMP_LOW: begin
                    next_st.lamp[7:4] = link.wdata[7:4];
                end
                ifcp_pkg::ADDR_LAMP_HIGH: begin
                    next_st.lamp[15:8] = link.wdata;
                end
                ifcp_pkg::ADDR_SYNTH_SEL: begin
                    next_st.sel = link.wdata[3:0];
                end
                // start engine, a byte while busy is dropped
                ifcp_pkg::ADDR_SYNTH_DATA: begin
                    if (!st.busy) begin
                        next_st.busy  = 1'b1;
                        next_st.shift = link.wdata;
                        next_st.nbits = 4'(ifcp_pkg::BITS_PER_BYTE);
                        next_st.sclk  = 1'b0;
                        next_st.cnt   = CW'(ifcp_pkg::EDGE_CYCLES);
                    end
                end
                ifcp_pkg::ADDR_SW_DIR: begin
                    next_st.sw_dir = link.wdata;
                end
                ifcp_pkg::ADDR_SW_VALUE: begin
                    next_st.sw_val = link.wdata;
                end
            endcase
        end

        // =========================================================
        // edge spacing timer
        if (st.busy) begin
            if (st.cnt > CW'(1)) begin
                next_st.cnt = st.cnt - CW'(1);
            end else begin
                next_st.cnt = CW'(ifcp_pkg::EDGE_CYCLES);
                if (!st.sclk) begin
                    next_st.sclk = 1'b1;
                end else begin
                    next_st.sclk  = 1'b0;
                    next_st.shift = {st.shift[6:0], 1'b0};
                    next_st.nbits = st.nbits - 4'h1;
                    if (st.nbits == 4'h1) begin
                        next_st.busy = 1'b0;
                    end
                end
            end
        end

        // =========================================================
        // register reads, zero when no read
        next_st.rdata = 8'h00;
        if (link.rd) begin
            unique case (link.addr)
                ifcp_pkg::ADDR_RELAY: begin
                    next_st.rdata = st.contact;
                end
                ifcp_pkg::ADDR_SYNTH_SEL: begin
                    next_st.rdata[ifcp_pkg::LOCK_LSB-1:0] = st.sel;
                    next_st.rdata[ifcp_pkg::LOCK_LSB +: 4] = st.lock;
                end
                ifcp_pkg::ADDR_SYNTH_DATA: begin
                    next_st.rdata[ifcp_pkg::BUSY_BIT] = st.busy;
                end
                ifcp_pkg::ADDR_SW_DIR: begin
                    next_st.rdata = st.sw_dir;
                end
                ifcp_pkg::ADDR_SW_VALUE: begin
                    next_st.rdata = st.swin;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // =========================================================
    // state register
    // reset idle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // =========================================================
    // outputs, all straight from state
    assign link.rdata    = st.rdata;
    assign detector_o    = st.det;
    assign relay_drive_o = st.relay;
    assign lamp_o        = st.lamp;
    assign synth_pick_o  = st.sel;
    assign synth_clock_o = st.sclk;
    // broadcast data, idles low once shifted out
    assign synth_data_o  = st.shift[7];
    assign switch_out_o  = st.sw_val;
    assign switch_oe_o   = st.sw_dir;
endmodule : ifcp_device

// File: testbench/ifcp_assertions.sv
// Purpose: link checks for the control port
// Assumes: one clock, rst_i async active high
// Notes:   watches the interface signals only
`timescale 1ns/10ps
module ifcp_assertions (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata
);
    logic sel_seen;
    logic data_seen;
    // ==========================================
    // writes since reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sel_seen  <= 1'b0;
            data_seen <= 1'b0;
        end else begin
            sel_seen  <= sel_seen | (wr && addr == ifcp_pkg::ADDR_SYNTH_SEL);
            data_seen <= data_seen | (wr && addr == ifcp_pkg::ADDR_SYNTH_DATA);
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    det_no_read_a: assert property (
        rd && addr == ifcp_pkg::ADDR_DETECTOR |=> rdata == 8'h00) else $error("detector read");
    lamp_no_read_a: assert property (
        rd && addr inside {3'h2, 3'h3} |=> rdata == 8'h00) else $error("lamp read");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
    sel_readback_a: assert property (
        wr && addr == 3'h4 ##1 rd && addr == 3'h4 |=> rdata[3:0] == $past(wdata[3:0], 2))
        else $error("select readback");
    dir_readback_a: assert property (
        wr && addr == 3'h6 ##1 rd && addr == 3'h6 |=> rdata == $past(wdata, 2))
        else $error("direction readback");
    busy_set_a: assert property (
        wr && addr == 3'h5 ##1 rd && addr == 3'h5 |=> rdata[7]) else $error("busy not set");
    sel_clear_a: assert property (
        rd && addr == 3'h4 && !sel_seen |=> rdata[3:0] == 4'h0) else $error("select not clear");
    busy_clear_a: assert property (
        rd && addr == 3'h5 && !data_seen |=> !rdata[7]) else $error("busy after reset");
endmodule : ifcp_assertions

// File: testbench/ifcp_bench.sv
// Purpose: host and device joined over the link
// Assumes: 250 MHz clock, software port at the host
// Notes:   a byte shift is far too long to finish, only its start is judged
`timescale 1ns/10ps
module ifcp_bench;
    logic clock_i = 1'b0, rst_i = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0;
    logic [2:0] sw_addr = 3'h0, det;
    logic [7:0] sw_wdata = 8'h00, sw_rdata, contact = 8'h3C, sw_ext = 8'h5A, r;
    logic [7:0] relay, sw_out, sw_oe, sw_line;
    logic [3:0] lock = 4'hA, pick;
    logic [15:0] lamp;
    logic sclk, sdat;
    int failures = 0, checked = 0;
    always #2 clock_i = ~clock_i;
    assign sw_line = (sw_oe & sw_out) | (~sw_oe & sw_ext);
    ifcp_if link (.clock_i(clock_i));
    ifcp_host ifcp_host_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link),
        .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
        .sw_rdata_o(sw_rdata));
    ifcp_device ifcp_device_inst (.clock_i(clock_i), .rst_i(rst_i), .link(link),
        .relay_contact_i(contact), .synth_locked_i(lock), .switch_in_i(sw_line),
        .detector_o(det), .relay_drive_o(relay), .lamp_o(lamp), .synth_pick_o(pick),
        .synth_clock_o(sclk), .synth_data_o(sdat), .switch_out_o(sw_out),
        .switch_oe_o(sw_oe));
    ifcp_assertions ifcp_assertions_inst (.clock_i(clock_i), .rst_i(rst_i),
        .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
    // ==========================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic put(input logic w, input logic [2:0] a, input logic [7:0] d);
        sw_wr <= w;
        sw_rd <= ~w;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clock_i);
    endtask : put
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        put(1'b1, a, d);
        sw_wr <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    // optional write, then a read of the same place with no gap
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        if (w) put(1'b1, a, d);
        put(1'b0, a, 8'h00);
        sw_rd <= 1'b0;
        repeat (4) @(posedge clock_i);
        r = sw_rdata;
    endtask : acc
    task automatic reset_pulse();
        rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
    endtask : reset_pulse
    // ==========================================
    // scenarios
    task automatic t_regs();
        wr(3'h0, 8'hFD);
        wr(3'h1, 8'hA5);
        wr(3'h2, 8'hF0);
        wr(3'h3, 8'h81);
        acc(1'b0, 3'h1, 8'h00);
        check(r, 8'h3C);
        acc(1'b0, 3'h0, 8'h00);
        check(r, 8'h00);
        check(det, 3'h5);
        check(relay, 8'hA5);
        acc(1'b0, 3'h2, 8'h00);
        check(r, 8'h00);
        acc(1'b0, 3'h3, 8'h00);
        check(r, 8'h00);
        check(lamp, 16'h81FA);
        acc(1'b1, 3'h4, 8'h05);
        check(r, 8'hA5);
        acc(1'b1, 3'h6, 8'h0F);
        check(r, 8'h0F);
        check(sw_oe, 8'h0F);
        // switch pins pass two flops before they read back
        wr(3'h7, 8'h96);
        repeat (2) @(posedge clock_i);
        acc(1'b0, 3'h7, 8'h00);
        check(r, 8'h56);
        check(sw_out, 8'h96);
        $display("register test done");
    endtask : t_regs
    task automatic t_synth(input logic [3:0] s, input logic [7:0] d);
        reset_pulse();
        acc(1'b0, 3'h5, 8'h00);
        check(r[7], 1'b0);
        acc(1'b0, 3'h4, 8'h00);
        check(r[3:0], 4'h0);
        wr(3'h4, {4'h0, s});
        acc(1'b1, 3'h5, d);
        check(r[7], 1'b1);
        check(pick, s);
        check(sdat, d[7]);
        // a byte written while busy is dropped
        wr(3'h5, ~d);
        repeat (1000) @(posedge clock_i);
        check({sclk, sdat}, {1'b0, d[7]});
        wr(3'h4, 8'h00);
        @(posedge clock_i);
        check(pick, 4'h0);
        $display("synth test done");
    endtask : t_synth
    task automatic tally_and_finish();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        t_regs();
        t_synth(4'hF, 8'hA3);
        t_synth(4'h2, 8'h7F);
        tally_and_finish();
    end
endmodule : ifcp_bench
